//--- tmr_pkg.sv
// package: register map, field layout and encodings for the capture/compare timer
//
// Contract
// - one 16-bit counter shared by three capture/compare channels
// - interrupt on counter overflow and on each channel event
// - channel zero has no pin output; period, capture and interrupt only
// - in up mode channel zero value sets the wrap count
// - real-time counter overflow pulses feed channel zero capture input A
// - remap bit picks one of two pin groups for capture inputs
// - pwm outputs reach both pin groups; function select and hiz trigger gate
// - timer output modulates serial transmit line for infrared diode
// - five infrared controls: enable, polarity, mode, source, software data
// - selected hiz trigger forces all timer output pads high impedance
// - hiz select 0 takes comparator output, 1 takes a port pin
package tmr_pkg;
	localparam int          NUM_CH       = 3;
	localparam int          CNT_W        = 16;
	// byte offsets of the registers
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_COUNT    = 8'h04;
	localparam logic [7:0]  OFS_CH0      = 8'h08;
	localparam logic [7:0]  OFS_CH_STEP  = 8'h04;
	localparam logic [7:0]  OFS_CCTL0    = 8'h14;
	localparam logic [7:0]  OFS_STATUS   = 8'h20;
	localparam logic [7:0]  OFS_MASK     = 8'h24;
	localparam logic [7:0]  OFS_SYSCFG   = 8'h28;
	// ctrl fields
	localparam int          CTRL_CLK_LSB = 0;
	localparam int          CTRL_MODE_LSB = 2;
	localparam int          CTRL_CLR_BIT = 4;
	// channel control fields
	localparam int          CC_CAP_BIT   = 0;
	localparam int          CC_SEL_LSB   = 1;
	localparam int          CC_EDGE_LSB  = 3;
	localparam int          CC_OMODE_LSB = 5;
	// system config fields
	localparam int          SC_REMAP_BIT = 0;
	localparam int          SC_IR_ENABLE_BIT = 1;
	localparam int          SC_IRPOL_BIT = 2;
	localparam int          SC_IRMOD_BIT = 3;
	localparam int          SC_IRSRC_BIT = 4;
	localparam int          SC_IRDAT_BIT = 5;
	localparam int          SC_HZSEL_BIT = 6;
	localparam int          SC_HZEN_BIT  = 7;
	// status bits: 0 overflow, 1..3 channels
	localparam int          ST_OVF_BIT   = 0;
	localparam int          ST_W         = 4;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	// counting modes
	typedef enum logic [1:0] {
		MODE_STOP = 2'h0,
		MODE_UP   = 2'h1,
		MODE_CONT = 2'h2,
		MODE_UPDN = 2'h3
	} mode_t;
	// capture input selection
	localparam logic [1:0]  CAP_A = 2'h0;
	localparam logic [1:0]  CAP_B = 2'h1;
	localparam logic [1:0]  CAP_GND = 2'h2;
	localparam logic [1:0]  CAP_VCC = 2'h3;
	// bus states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DATA = 2'b10
	} bus_st_t;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

//--- tmr_chan.sv
// capture/compare channel: capture mux, edge detect, compare, output unit
`timescale 1ns/100ps
module tmr_chan
	import tmr_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         core_clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         tick_in,
	input  wire logic [W-1:0] count_in,
	input  wire logic [W-1:0] period_in,
	input  wire logic         cap_mode_in,
	input  wire logic [1:0]   cap_sel_in,
	input  wire logic [1:0]   cap_edge_in,
	input  wire logic [2:0]   out_mode_in,
	input  wire logic         cap_a_in,
	input  wire logic         cap_b_in,
	input  wire logic         wr_in,
	input  wire logic [W-1:0] wdata_in,
	output logic      [W-1:0] value_out,
	output logic              event_out,
	output logic              pwm_out
);
	logic [W-1:0] value_q, value_d;
	logic         cin_q, cin_d, pwm_q, pwm_d;
	logic         cin, rise, fall, hit, wrap;

	// refuse widths the count and capture paths cannot serve
	if (W < 2 || W > 32) begin : g_bad_width
		$error("channel width out of range");
	end

	// capture input multiplexer
	always_comb begin
		case (cap_sel_in)
			CAP_A:   cin = cap_a_in;
			CAP_B:   cin = cap_b_in;
			CAP_GND: cin = 1'b0;
			default: cin = 1'b1;
		endcase
	end

	assign rise = cin & ~cin_q;
	assign fall = ~cin & cin_q;
	assign hit  = tick_in & (count_in == value_q);
	assign wrap = tick_in & (count_in == period_in);

	// capture or compare next state
	always_comb begin
		value_d   = value_q;
		cin_d     = cin;
		pwm_d     = pwm_q;
		event_out = 1'b0;
		if (cap_mode_in) begin
			if ((cap_edge_in[0] & rise) | (cap_edge_in[1] & fall)) begin
				value_d   = count_in;
				event_out = 1'b1;
			end
		end else if (hit) begin
			event_out = 1'b1;
			case (out_mode_in)
				3'h1: pwm_d = 1'b1;
				3'h4: pwm_d = ~pwm_q;
				3'h5: pwm_d = 1'b0;
				3'h7: pwm_d = 1'b0;
				default: pwm_d = pwm_q;
			endcase
		end else if (wrap && out_mode_in == 3'h7) begin
			pwm_d = 1'b1;
		end
		if (wr_in) begin
			value_d = wdata_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			value_q <= '0;
			cin_q   <= 1'b0;
			pwm_q   <= 1'b0;
		end else begin
			value_q <= value_d;
			cin_q   <= cin_d;
			pwm_q   <= pwm_d;
		end
	end

	assign value_out = value_q;
	assign pwm_out   = pwm_q;
endmodule

//--- tmr_top.sv
// timer top: counter, ahb-lite registers, pin routing, infrared and hiz
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module tmr_top
	import tmr_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	input  wire logic        ext_timer_clock_in,
	input  wire logic        aux_clock_in,
	input  wire logic        subsystem_clock_in,
	input  wire logic        touch_internal_clock_in,
	input  wire logic        rtc_overflow_in,
	input  wire logic        low_freq_clock_in,
	input  wire logic        comparator_in,
	input  wire logic        touch_capture_in,
	input  wire logic [1:0]  grp0_pin_in,
	input  wire logic [1:0]  grp1_pin_in,
	input  wire logic        hiz_pin_in,
	input  wire logic [1:0]  grp0_func_sel_in,
	input  wire logic [1:0]  grp1_func_sel_in,
	input  wire logic        serial_tx_in,
	output logic      [1:0]  grp0_pwm_out,
	output logic      [1:0]  grp0_pwm_oe_out,
	output logic      [1:0]  grp1_pwm_out,
	output logic      [1:0]  grp1_pwm_oe_out,
	output logic             infrared_out,
	output logic             output_hiz_trigger_out,
	output logic             irq_out
);
	// synchronisers for all asynchronous pins and clocks
	localparam int SYNC_W = 14;
	logic [SYNC_W-1:0] s1_q, s2_q;
	logic [3:0]        s3_q; // only the clock sources need a third stage for edge detect
	logic [SYNC_W-1:0] raw;
	assign raw = {ext_timer_clock_in, aux_clock_in, subsystem_clock_in, touch_internal_clock_in,
		rtc_overflow_in, low_freq_clock_in, comparator_in, touch_capture_in,
		grp0_pin_in, grp1_pin_in, hiz_pin_in, serial_tx_in};
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q[13:10];
		end
	end
	logic [3:0] clk_sync, clk_prev;
	logic       rtc_s, lfc_s, cmp_s, tch_s, hzp_s, tx_s;
	logic [1:0] g0_s, g1_s;
	assign clk_sync = s2_q[13:10];
	assign clk_prev = s3_q;
	assign rtc_s = s2_q[9];
	assign lfc_s = s2_q[8];
	assign cmp_s = s2_q[7];
	assign tch_s = s2_q[6];
	assign g0_s  = s2_q[5:4];
	assign g1_s  = s2_q[3:2];
	assign hzp_s = s2_q[1];
	assign tx_s  = s2_q[0];

	// registers
	logic [4:0]        ctrl_q, ctrl_d;
	logic [CNT_W-1:0]  count_q, count_d;
	logic              dir_down_q, dir_down_d;
	logic [5:0]        cctl_q [NUM_CH], cctl_d [NUM_CH];
	logic [ST_W-1:0]   status_q, status_d, mask_q, mask_d;
	logic [7:0]        syscfg_q, syscfg_d;
	mode_t             mode;
	logic [1:0]        clk_sel;
	logic              tick, ovf;
	logic [3:0]        clk_rise;
	logic [NUM_CH-1:0] ch_event, ch_pwm, ch_wr;
	logic [CNT_W-1:0]  ch_val [NUM_CH];

	// bus address phase capture
	bus_st_t    bus_q, bus_d;
	logic [7:0] addr_q, addr_d;
	logic       wr_q, wr_d;
	logic       bus_wr;

	assign mode    = mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
	assign clk_sel = ctrl_q[CTRL_CLK_LSB +: 2];
	assign clk_rise = clk_sync & ~clk_prev;
	assign tick    = clk_rise[clk_sel] & (mode != MODE_STOP);
	assign bus_wr  = (bus_q == BUS_DATA) & wr_q;

	// decode a channel register from a byte offset
	function automatic logic is_ch(input logic [7:0] a, input logic [7:0] base, input int i);
		is_ch = (a == base + 8'(i) * OFS_CH_STEP);
	endfunction

	// counter next state
	always_comb begin
		count_d    = count_q;
		dir_down_d = dir_down_q;
		ovf        = 1'b0;
		if (tick) begin
			case (mode)
				MODE_UP: begin
					if (count_q >= ch_val[0]) begin
						count_d = CNT_ZERO;
						ovf     = 1'b1;
					end else begin
						count_d = count_q + 16'h0001;
					end
				end
				MODE_CONT: begin
					count_d = count_q + 16'h0001;
					ovf     = (count_q == CNT_MAX);
				end
				MODE_UPDN: begin
					if (dir_down_q) begin
						count_d = count_q - 16'h0001;
						if (count_q == 16'h0001) begin
							dir_down_d = 1'b0;
							ovf        = 1'b1;
						end
					end else if (count_q >= ch_val[0]) begin
						count_d    = count_q - 16'h0001;
						dir_down_d = 1'b1;
					end else begin
						count_d = count_q + 16'h0001;
					end
				end
				default: count_d = count_q;
			endcase
		end
		if (bus_wr && addr_q == OFS_COUNT) begin
			count_d = hwdata_in[CNT_W-1:0];
		end
		if (bus_wr && addr_q == OFS_CTRL && hwdata_in[CTRL_CLR_BIT]) begin
			count_d    = CNT_ZERO;
			dir_down_d = 1'b0;
		end
	end

	// register file next state; hardware set wins over write-one clear
	always_comb begin
		ctrl_d   = ctrl_q;
		mask_d   = mask_q;
		syscfg_d = syscfg_q;
		status_d = status_q;
		for (int i = 0; i < NUM_CH; i++) begin
			cctl_d[i] = cctl_q[i];
			if (bus_wr && is_ch(addr_q, OFS_CCTL0, i)) begin
				cctl_d[i] = hwdata_in[5:0];
			end
		end
		if (bus_wr) begin
			case (addr_q)
				OFS_CTRL:   ctrl_d   = {1'b0, hwdata_in[3:0]};
				OFS_MASK:   mask_d   = hwdata_in[ST_W-1:0];
				OFS_SYSCFG: syscfg_d = hwdata_in[7:0];
				OFS_STATUS: status_d = status_q & ~hwdata_in[ST_W-1:0];
				default:    ctrl_d   = ctrl_q;
			endcase
		end
		status_d = status_d | {ch_event, ovf};
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q     <= '0;
			count_q    <= CNT_ZERO;
			dir_down_q <= 1'b0;
			status_q   <= '0;
			mask_q     <= '0;
			syscfg_q   <= '0;
			for (int i = 0; i < NUM_CH; i++) begin
				cctl_q[i] <= '0;
			end
		end else begin
			ctrl_q     <= ctrl_d;
			count_q    <= count_d;
			dir_down_q <= dir_down_d;
			status_q   <= status_d;
			mask_q     <= mask_d;
			syscfg_q   <= syscfg_d;
			for (int i = 0; i < NUM_CH; i++) begin
				cctl_q[i] <= cctl_d[i];
			end
		end
	end

	assign irq_out = |(status_q & mask_q);

	// capture input routing per channel
	logic [NUM_CH-1:0] cap_a, cap_b;
	assign cap_a[0] = rtc_s;
	assign cap_b[0] = lfc_s;
	assign cap_a[1] = syscfg_q[SC_REMAP_BIT] ? g1_s[0] : g0_s[0];
	assign cap_a[2] = syscfg_q[SC_REMAP_BIT] ? g1_s[1] : g0_s[1];
	assign cap_b[1] = cmp_s;
	assign cap_b[2] = tch_s;

	generate
		for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
			assign ch_wr[g] = bus_wr & is_ch(addr_q, OFS_CH0, g);
			tmr_chan #(.W(CNT_W)) u_chan (
				.core_clk_in (core_clk_in),
				.rst_n_in    (rst_n_in),
				.tick_in     (tick),
				.count_in    (count_q),
				.period_in   (ch_val[0]),
				.cap_mode_in (cctl_q[g][CC_CAP_BIT]),
				.cap_sel_in  (cctl_q[g][CC_SEL_LSB +: 2]),
				.cap_edge_in (cctl_q[g][CC_EDGE_LSB +: 2]),
				.out_mode_in (cctl_q[g][CC_OMODE_LSB] ? 3'h7 : 3'h0),
				.cap_a_in    (cap_a[g]),
				.cap_b_in    (cap_b[g]),
				.wr_in       (ch_wr[g]),
				.wdata_in    (hwdata_in[CNT_W-1:0]),
				.value_out   (ch_val[g]),
				.event_out   (ch_event[g]),
				.pwm_out     (ch_pwm[g])
			);
		end
	endgenerate

	// hiz trigger source and pad enables; channel zero has no pad
	logic hiz;
	assign hiz = syscfg_q[SC_HZEN_BIT] & (syscfg_q[SC_HZSEL_BIT] ? hzp_s : cmp_s);
	assign output_hiz_trigger_out = hiz;
	assign grp0_pwm_out    = ch_pwm[2:1];
	assign grp1_pwm_out    = ch_pwm[2:1];
	assign grp0_pwm_oe_out = grp0_func_sel_in & {2{~hiz}};
	assign grp1_pwm_oe_out = grp1_func_sel_in & {2{~hiz}};

	// infrared modulation of the serial line
	logic ir_data, ir_mod, ir_q, ir_d;
	always_comb begin
		ir_data = syscfg_q[SC_IRSRC_BIT] ? syscfg_q[SC_IRDAT_BIT] : tx_s;
		if (syscfg_q[SC_IRMOD_BIT]) begin
			ir_mod = ir_data ? ch_pwm[1] : ch_pwm[2];
		end else begin
			ir_mod = ir_data & ch_pwm[1];
		end
		if (syscfg_q[SC_IR_ENABLE_BIT]) begin
			ir_d = ir_mod ^ syscfg_q[SC_IRPOL_BIT];
		end else begin
			ir_d = tx_s;
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ir_q <= 1'b0;
		end else begin
			ir_q <= ir_d;
		end
	end
	assign infrared_out = ir_q;

	// ahb-lite slave: zero wait, okay always
	always_comb begin
		bus_d  = bus_q;
		addr_d = addr_q;
		wr_d   = wr_q;
		if (hready_in) begin
			if (hsel_in && htrans_in == HTRANS_NONSEQ) begin
				bus_d  = BUS_DATA;
				addr_d = haddr_in[7:0];
				wr_d   = hwrite_in;
			end else begin
				bus_d = BUS_IDLE;
				wr_d  = 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_q  <= BUS_IDLE;
			addr_q <= '0;
			wr_q   <= 1'b0;
		end else begin
			bus_q  <= bus_d;
			addr_q <= addr_d;
			wr_q   <= wr_d;
		end
	end

	// read data mux; unmapped reads zero
	always_comb begin
		hrdata_out = 32'h0000_0000;
		case (addr_q)
			OFS_CTRL:   hrdata_out[4:0]        = ctrl_q;
			OFS_COUNT:  hrdata_out[CNT_W-1:0]  = count_q;
			OFS_STATUS: hrdata_out[ST_W-1:0]   = status_q;
			OFS_MASK:   hrdata_out[ST_W-1:0]   = mask_q;
			OFS_SYSCFG: hrdata_out[7:0]        = syscfg_q;
			default: begin
				for (int i = 0; i < NUM_CH; i++) begin
					if (is_ch(addr_q, OFS_CH0, i)) hrdata_out[CNT_W-1:0] = ch_val[i];
					if (is_ch(addr_q, OFS_CCTL0, i)) hrdata_out[5:0] = cctl_q[i];
				end
			end
		endcase
	end
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// checks
	ovf_sets_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		ovf |=> status_q[ST_OVF_BIT]) else $error("overflow flag not set");
	irq_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(|(status_q & mask_q)) == irq_out) else $error("irq mismatch");
	up_wrap_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(tick && mode == MODE_UP && count_q >= ch_val[0] && !bus_wr) |=> count_q == CNT_ZERO)
		else $error("up mode wrap wrong");
	hiz_pads_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		hiz |-> (grp0_pwm_oe_out == 2'h0 && grp1_pwm_oe_out == 2'h0)) else $error("pads not hiz");
	both_grp_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		grp0_pwm_out == grp1_pwm_out) else $error("groups differ");
	cont_inc_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(tick && mode == MODE_CONT && !bus_wr) |=> count_q == $past(count_q) + 16'h0001)
		else $error("count not incremented");
	ir_off_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!syscfg_q[SC_IR_ENABLE_BIT] |=> infrared_out == $past(tx_s)) else $error("ir bypass wrong");
	hz_sel_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(syscfg_q[SC_HZEN_BIT] && !syscfg_q[SC_HZSEL_BIT]) |-> hiz == cmp_s) else $error("hiz src");
endmodule

//--- tmr_periph_model.sv
// partner model: slow clock sources and real-time counter overflow pulses
`timescale 1ns/100ps
module tmr_periph_model (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic rtc_fire_in,
	output logic      ext_timer_clock_out,
	output logic      aux_clock_out,
	output logic      subsystem_clock_out,
	output logic      touch_internal_clock_out,
	output logic      low_freq_clock_out,
	output logic      rtc_overflow_out
);
	logic [7:0] div_q;
	logic [7:0] div_d;
	logic [2:0] rtc_len_q;
	logic [2:0] rtc_len_d;

	// divider and overflow pulse stretcher; pulse spans 4 cycles so the pin synchroniser sees it
	always_comb begin
		div_d = div_q + 8'h01;
		rtc_len_d = rtc_len_q;
		if (rtc_fire_in) begin
			rtc_len_d = 3'h4;
		end else if (rtc_len_q != 3'h0) begin
			rtc_len_d = rtc_len_q - 3'h1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_q <= 8'h00;
			rtc_len_q <= 3'h0;
		end else begin
			div_q <= div_d;
			rtc_len_q <= rtc_len_d;
		end
	end

	// every source stays well below half the core rate
	assign subsystem_clock_out = div_q[1];
	assign aux_clock_out = div_q[2];
	assign ext_timer_clock_out = div_q[3];
	assign touch_internal_clock_out = div_q[4];
	assign low_freq_clock_out = div_q[7];
	assign rtc_overflow_out = (rtc_len_q != 3'h0);
endmodule

//--- timer_capture_pwm_ir_tb.sv
// testbench: bus tasks, scenarios and verdict for the capture/compare timer
`timescale 1ns/100ps
module timer_capture_pwm_ir_tb import tmr_pkg::*; ;
	logic        core_clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, rtc_fire = 1'b0;
	logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, seed = 32'h97401967, r0, r1;
	logic [1:0]  htrans_in = 2'h0, grp0_pin_in = 2'h0, grp1_pin_in = 2'h0;
	logic [1:0]  grp0_func_sel_in = 2'h0, grp1_func_sel_in = 2'h0, grp0_pwm_out, grp1_pwm_out;
	logic [1:0]  grp0_pwm_oe_out, grp1_pwm_oe_out;
	logic [2:0]  hsize_in = 3'h2;
	logic        comparator_in = 1'b0, touch_capture_in = 1'b0, hiz_pin_in = 1'b0, serial_tx_in = 1'b0;
	logic        hreadyout_out, hresp_out, infrared_out, output_hiz_trigger_out, irq_out, seen_hi, seen_lo;
	logic [15:0] p;
	wire         hready_in, ext_timer_clock_in, aux_clock_in, subsystem_clock_in;
	wire         touch_internal_clock_in, low_freq_clock_in, rtc_overflow_in;
	int          err_count = 0;
	int          comparisons = 0;

	assign hready_in = hreadyout_out;
	always #2.5 core_clk_in = ~core_clk_in;

	tmr_top dut (.core_clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
		.hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .ext_timer_clock_in, .aux_clock_in,
		.subsystem_clock_in, .touch_internal_clock_in, .rtc_overflow_in, .low_freq_clock_in, .comparator_in,
		.touch_capture_in, .grp0_pin_in, .grp1_pin_in, .hiz_pin_in, .grp0_func_sel_in, .grp1_func_sel_in,
		.serial_tx_in, .grp0_pwm_out, .grp0_pwm_oe_out, .grp1_pwm_out, .grp1_pwm_oe_out, .infrared_out,
		.output_hiz_trigger_out, .irq_out);

	tmr_periph_model partner (.core_clk_in, .rst_n_in, .rtc_fire_in(rtc_fire),
		.ext_timer_clock_out(ext_timer_clock_in), .aux_clock_out(aux_clock_in),
		.subsystem_clock_out(subsystem_clock_in), .touch_internal_clock_out(touch_internal_clock_in),
		.low_freq_clock_out(low_freq_clock_in), .rtc_overflow_out(rtc_overflow_in));

	// fixed-seed shift register for repeatable random values
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic results;
		$display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_pin(input string what, input logic exp, input logic got);
		check_reg(what, {31'h0, exp}, {31'h0, got});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask

	// bounded wait for hready at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (hreadyout_out !== 1'b1 && n < 64);
		if (n >= 64) begin
			err_count++;
			$display("unexpected bus wait: expected ready seen none");
			results();
		end
	endtask

	// one single word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		@(posedge core_clk_in);
		hsel_in <= 1'b1;
		haddr_in <= {24'h0, a};
		htrans_in <= HTRANS_NONSEQ;
		hwrite_in <= w;
		wait_ready();
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= wd;
		wait_ready();
		r = hrdata_out;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask

	initial begin
		cyc(60000);
		err_count++;
		$display("unexpected run length: expected end seen timeout");
		results();
	end

	initial begin
		cyc(10);
		rst_n_in <= 1'b1;
		// reset values and an unmapped word
		wr(8'h40, 32'hFFFFFFFF);
		rd(8'h40, r0);
		check_reg("unmapped word", 32'h0, r0);
		check_pin("bus response", 1'b0, hresp_out);
		rd(OFS_SYSCFG, r0);
		check_reg("syscfg reset", 32'h0, r0);
		rd(OFS_MASK, r0);
		check_reg("mask reset", 32'h0, r0);
		$display("test reset done");
		// every clock source advances the counter in continuous mode
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTRL, 32'h10);
			wr(OFS_CTRL, {28'h0, MODE_CONT, s[1:0]});
			cyc(120);
			rd(OFS_COUNT, r0);
			cyc(120);
			rd(OFS_COUNT, r1);
			check_pin("count advances", 1'b1, r1[15:0] > r0[15:0]);
		end
		$display("test clock sources done");
		// up mode with a random period, pwm on both pin groups
		seed = lfsr_next(seed);
		p = 16'h8 + {11'h0, seed[4:0]};
		grp0_func_sel_in <= seed[6:5];
		grp1_func_sel_in <= seed[8:7];
		serial_tx_in <= seed[9];
		wr(OFS_CTRL, 32'h10);
		wr(OFS_CH0, {16'h0, p});
		wr(OFS_CH0 + OFS_CH_STEP, {17'h0, p[15:1]});
		wr(OFS_CCTL0 + 8'h04, 32'h20);
		wr(OFS_STATUS, 32'hF);
		wr(OFS_CTRL, {28'h0, MODE_UP, 2'h1});
		seen_hi = 1'b0;
		seen_lo = 1'b0;
		for (int i = 0; i < 60; i++) begin
			rd(OFS_COUNT, r0);
			check_pin("count within period", 1'b1, r0[15:0] <= p);
			check_reg("pwm groups", {30'h0, grp0_pwm_out}, {30'h0, grp1_pwm_out});
			check_reg("pwm enables", {28'h0, grp1_func_sel_in, grp0_func_sel_in},
				{28'h0, grp1_pwm_oe_out, grp0_pwm_oe_out});
			seen_hi = seen_hi | grp0_pwm_out[0];
			seen_lo = seen_lo | ~grp0_pwm_out[0];
			cyc(8);
		end
		check_pin("pwm toggles", 1'b1, seen_hi & seen_lo);
		rd(OFS_STATUS, r0);
		check_pin("overflow flag", 1'b1, r0[ST_OVF_BIT]);
		check_pin("channel one flag", 1'b1, r0[2]);
		$display("test period done");
		// up-down mode turns at the period and flags overflow back at zero
		wr(OFS_CTRL, 32'h0000_0010);
		wr(OFS_STATUS, 32'h0000_000F);
		wr(OFS_CTRL, {28'h0, MODE_UPDN, 2'h1});
		for (int i = 0; i < 40; i++) begin
			rd(OFS_COUNT, r0);
			check_pin("updown within period", 1'b1, r0[15:0] <= p);
			cyc(8);
		end
		rd(OFS_STATUS, r0);
		check_pin("updown overflow flag", 1'b1, r0[ST_OVF_BIT]);
		$display("test updown done");
		// rtc overflow captured by channel zero on a cleared, stopped counter
		wr(OFS_CTRL, 32'h10);
		wr(OFS_CCTL0, 32'h9);
		wr(OFS_STATUS, 32'hF);
		rtc_fire <= 1'b1;
		cyc(1);
		rtc_fire <= 1'b0;
		cyc(12);
		rd(OFS_STATUS, r0);
		check_pin("channel zero flag", 1'b1, r0[1]);
		rd(OFS_CH0, r0);
		check_reg("channel zero capture", 32'h0, r0);
		$display("test rtc capture done");
		// remap picks one pin group for channel one capture
		wr(OFS_CCTL0 + 8'h04, 32'h9);
		for (int r = 0; r < 2; r++) begin
			wr(OFS_SYSCFG, r);
			grp0_pin_in <= 2'h0;
			grp1_pin_in <= 2'h0;
			cyc(8);
			wr(OFS_STATUS, 32'hF);
			if (r == 0) grp1_pin_in <= 2'h1;
			else grp0_pin_in <= 2'h1;
			cyc(8);
			rd(OFS_STATUS, r0);
			check_pin("ignored group", 1'b0, r0[2]);
			if (r == 0) grp0_pin_in <= 2'h1;
			else grp1_pin_in <= 2'h1;
			cyc(8);
			rd(OFS_STATUS, r0);
			check_pin("selected group", 1'b1, r0[2]);
		end
		$display("test remap done");
		// interrupt line follows unmasked sticky flags
		wr(OFS_MASK, 32'h0);
		cyc(2);
		check_pin("irq masked", 1'b0, irq_out);
		wr(OFS_MASK, 32'h4);
		cyc(2);
		check_pin("irq raised", 1'b1, irq_out);
		wr(OFS_STATUS, 32'h4);
		cyc(2);
		check_pin("irq cleared", 1'b0, irq_out);
		$display("test interrupt done");
		// channel two captures its B input from the touch logic on a stopped counter
		wr(OFS_CH0 + 8'h08, 32'h0000_1234);
		wr(OFS_CCTL0 + 8'h08, 32'h0000_000B);
		wr(OFS_STATUS, 32'h0000_000F);
		touch_capture_in <= 1'b1;
		cyc(8);
		rd(OFS_STATUS, r0);
		check_pin("channel two flag", 1'b1, r0[3]);
		rd(OFS_CH0 + 8'h08, r0);
		check_reg("channel two capture", 32'h0, r0);
		$display("test touch capture done");
		// high impedance trigger from comparator or port pin
		grp0_func_sel_in <= 2'h3;
		grp1_func_sel_in <= 2'h3;
		for (int k = 0; k < 4; k++) begin
			comparator_in <= k[0];
			hiz_pin_in <= ~k[0];
			wr(OFS_SYSCFG, {24'h0, 1'b1, k[1], 6'h0});
			cyc(6);
			check_pin("hiz trigger", k[1] ? ~k[0] : k[0], output_hiz_trigger_out);
			check_reg("oe under hiz", (k[1] ^ k[0]) ? 32'h0 : 32'h3, {30'h0, grp1_pwm_oe_out});
		end
		$display("test hiz done");
		// infrared line, software data low, both polarities, amplitude and frequency shift
		// frequency shift with data low picks channel two, which never drives pwm here
		for (int m = 0; m < 4; m++) begin
			wr(OFS_SYSCFG, {26'h0, 1'b0, 1'b1, m[1], m[0], 1'b1, 1'b0});
			cyc(6);
			check_pin("infrared idle", m[0], infrared_out);
		end
		// disabled modulation passes the serial line straight through, polarity ignored
		wr(OFS_SYSCFG, 32'h0000_0004);
		cyc(6);
		check_pin("infrared bypass", serial_tx_in, infrared_out);
		$display("test infrared done");
		results();
	end
endmodule
